/* File: logic/pielc_pkg.sv */
// Purpose: shared constants and helpers for the pulse, idling and end-limit axis block
// Assumes: 100 MHz core clock, one axis
// Notes: register map uses word indices on a plain strobe port
// Behaviour
// - completion at end of last pulse cycle (0) or last pulse width (1)
// - width control on: constant pulse width below about 2.44 kpps; off: no hold
// - held width about 200 us; otherwise pulses run near half duty
// - idle count 0 or 1: acceleration starts with the first pulse
// - idle count n of 2 to 7: n-1 pulses at start speed, accelerate on nth
// - idling pulses count inside the feed amount in positioning mode
// - idling counter readable in the speed readback register
// - limit in feed direction while moving stops the motor, immediately or decelerating
// - after a limit stop the axis stays stopped; no automatic restart
// - start refused toward a direction whose limit input is active
// - stop method 0 immediate, 1 deceleration stop for high speed starts only
// - filter on ignores limit pulses shorter than 150 ns; off passes all
// - plus and minus limit status bits read 1 when active
// - limit stop sets an error cause flag readable in the error register
// - timer mode ignores limits but status bits still update
// - polarity pin low means active-high limits, high means active-low
// - origin modes use their own limit response, not the generic stop
package pielc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLD_US = 200;
  localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int SLOW_PPS = 2440;
  localparam int SLOW_PER_CYC = CLK_HZ / SLOW_PPS;
  localparam int FILT_NS = 150;
  localparam int FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PW = 20;
  localparam int FW = 24;
  // register word indices
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_MODE = 4'h1;
  localparam logic [3:0] A_ENV1 = 4'h2;
  localparam logic [3:0] A_ENV2 = 4'h3;
  localparam logic [3:0] A_FEED = 4'h4;
  localparam logic [3:0] A_SPER = 4'h5;
  localparam logic [3:0] A_HPER = 4'h6;
  localparam logic [3:0] A_STEP = 4'h7;
  localparam logic [3:0] A_SPD = 4'h8;
  localparam logic [3:0] A_STS = 4'h9;
  localparam logic [3:0] A_ERR = 4'hA;
  // field positions
  localparam int B_START = 0;
  localparam int B_STOPI = 1;
  localparam int B_STOPD = 2;
  localparam int B_DIR = 4;
  localparam int B_HI = 5;
  localparam int B_METM = 8;
  localparam int B_ELM = 3;
  localparam int B_FDIS = 24;
  localparam int B_WDIS = 25;
  localparam int B_IDL = 16;
  localparam int B_IDC = 24;
  // reset values and operation mode codes
  localparam logic [PW-1:0] SPER_RST = 20'h186A0;
  localparam logic [PW-1:0] HPER_RST = 20'h02710;
  localparam logic [PW-1:0] STEP_RST = 20'h003E8;
  localparam logic [FW-1:0] FEED_RST = 24'h000000;
  localparam logic [1:0] M_POS = 2'h0;
  localparam logic [1:0] M_CONT = 2'h1;
  localparam logic [1:0] M_TIMER = 2'h2;
  localparam logic [1:0] M_ORIGIN = 2'h3;

  // one ramp step toward a faster period, floored at the target
  function automatic logic [PW-1:0] ramp_dn(input logic [PW-1:0] cur, input logic [PW-1:0] stp,
                                            input logic [PW-1:0] lim);
    ramp_dn = (cur > lim + stp) ? cur - stp : lim;
  endfunction

  // one ramp step toward a slower period, capped at the start period
  function automatic logic [PW-1:0] ramp_up(input logic [PW-1:0] cur, input logic [PW-1:0] stp,
                                            input logic [PW-1:0] lim);
    ramp_up = (cur + stp < lim) ? cur + stp : lim;
  endfunction
endpackage

/* File: logic/pielc_pulse_if.sv */
`timescale 1ns/10ps
// Purpose: link between axis sequencer and pulse timer
// Assumes: single clock
// Notes: fire is taken only while ready is high
interface pielc_pulse_if;
  import pielc_pkg::*;
  logic fire;
  logic abort;
  logic quiet;
  logic [PW-1:0] per;
  logic [PW-1:0] wid;
  logic ready;
  logic pulse;
  logic wid_end;
  logic cyc_end;
  modport gen (input fire, abort, quiet, per, wid, output ready, pulse, wid_end, cyc_end);
  modport ctl (output fire, abort, quiet, per, wid, input ready, pulse, wid_end, cyc_end);
endinterface

/* File: logic/pielc_pulse_gen.sv */
`timescale 1ns/10ps
// Purpose: emits one command pulse per fire unless quiet, period and width in cycles
// Assumes: per >= 2, 1 <= wid < per
// Notes: a fire in the last cycle of a period gives back-to-back pulses
module pielc_pulse_gen import pielc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  pielc_pulse_if.gen pg
);
  logic active;
  logic [PW-1:0] cnt;
  logic [PW-1:0] per_q;
  logic [PW-1:0] wid_q;
  logic pulse_q;
  wire last = active && (cnt == per_q - 20'h00001);

  // handshake flags stay combinational
  assign pg.ready = !active || last;
  assign pg.cyc_end = last;
  assign pg.wid_end = active && (cnt == wid_q - 20'h00001);
  assign pg.pulse = pulse_q;

  // period counter and pulse level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active <= 1'b0;
      cnt <= '0;
      per_q <= '0;
      wid_q <= '0;
      pulse_q <= 1'b0;
    end else if (pg.abort) begin
      active <= 1'b0;
      pulse_q <= 1'b0;
    end else if (pg.fire && pg.ready) begin
      active <= 1'b1;
      cnt <= '0;
      per_q <= pg.per;
      wid_q <= pg.wid;
      pulse_q <= !pg.quiet;
    end else if (active) begin
      cnt <= cnt + 20'h00001;
      if (last) active <= 1'b0;
      if (pg.wid_end) pulse_q <= 1'b0;
    end
  end
endmodule // pielc_pulse_gen

/* File: logic/pielc_limit_in.sv */
`timescale 1ns/10ps
// Purpose: end-limit input conditioning: sync, polarity, glitch filter
// Assumes: raw input asynchronous to the clock
// Notes: filter adds FILT-1 cycles of latency when enabled
module pielc_limit_in import pielc_pkg::*; #(
  parameter int FILT = FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  input wire logic pol_i,
  input wire logic fdis_i,
  output logic act_o
);
  logic s1;
  logic s2;
  logic [4:0] cnt;
  wire lvl = s2 ^ pol_i;
  wire held = cnt == 5'(FILT - 1);

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
    end
  end

  // output follows only after the level holds FILT cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      act_o <= 1'b0;
    end else if (fdis_i || lvl == act_o) begin
      cnt <= '0;
      act_o <= lvl;
    end else if (held) begin
      cnt <= '0;
      act_o <= lvl;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
endmodule // pielc_limit_in

/* File: logic/pielc_top.sv */
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// Purpose: one axis: pulse width, completion timing, idling and end-limit stop
// Assumes: registers on a plain strobe port, read data one cycle after strobe
// Notes: periods are in core clock cycles; minimum period 2
module pielc_top import pielc_pkg::*; #(
  parameter int HOLD_CYC_P = HOLD_CYC,
  parameter int SLOW_PER_P = SLOW_PER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic plus_end_limit_i,
  input wire logic minus_end_limit_i,
  input wire logic limit_polarity_pin_i,
  output logic pulse_o,
  output logic dir_o,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DECEL = 4'b0100,
    ST_TAIL = 4'b1000
  } pielc_state_e;

  logic rs1;
  logic rst_n;
  pielc_state_e st;
  pielc_state_e next_st;
  logic [1:0] op_mode;
  logic metm;
  logic stop_meth;
  logic fdis;
  logic wdis;
  logic [2:0] idle_set;
  logic [FW-1:0] feed;
  logic [PW-1:0] start_per;
  logic [PW-1:0] high_per;
  logic [PW-1:0] step_per;
  logic dir;
  logic hi_start;
  logic [FW-1:0] issued;
  logic [FW-1:0] ramp_n;
  logic [PW-1:0] cur_per;
  logic [2:0] idle_ctr;
  logic err_p;
  logic err_m;
  logic done_q;
  logic p_act;
  logic m_act;

  pielc_pulse_if pg ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rst_n <= rs1;
    end
  end

  // limit conditioning, one per direction
  pielc_limit_in u_plus (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .raw_i(plus_end_limit_i),
    .pol_i(limit_polarity_pin_i),
    .fdis_i(fdis),
    .act_o(p_act)
  );
  pielc_limit_in u_minus (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .raw_i(minus_end_limit_i),
    .pol_i(limit_polarity_pin_i),
    .fdis_i(fdis),
    .act_o(m_act)
  );

  pielc_pulse_gen u_gen (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pg(pg.gen)
  );

  // register strobe decode
  wire wr_cmd = reg_wr_i && reg_addr_i == A_CMD;
  wire wr_err = reg_wr_i && reg_addr_i == A_ERR;
  wire req_dir = reg_wdata_i[B_DIR];
  wire is_idle = st == ST_IDLE;
  wire moving = st == ST_RUN || st == ST_DECEL;
  wire timer = op_mode == M_TIMER;
  wire origin = op_mode == M_ORIGIN;
  wire counted = op_mode == M_POS || timer;

  // start handling; a blocked direction is refused outright
  wire start_req = wr_cmd && reg_wdata_i[B_START] && is_idle;
  wire lim_req = req_dir ? m_act : p_act;
  wire refused = start_req && !timer && !origin && lim_req;
  wire start_ok = start_req && !refused && (feed != '0 || !counted);

  // limit in feed direction while moving; timer mode ignores it
  wire lim_now = dir ? m_act : p_act;
  wire lim_hit = moving && !timer && lim_now;
  // origin modes end on the limit without the generic error path
  wire hit_err = lim_hit && !origin;
  wire use_dec = stop_meth && hi_start && !origin;
  wire stop_imm = moving && ((wr_cmd && reg_wdata_i[B_STOPI]) || (lim_hit && !use_dec));
  wire stop_dec = st == ST_RUN && ((wr_cmd && reg_wdata_i[B_STOPD]) || (lim_hit && use_dec));

  // feed bookkeeping; idling pulses live inside the feed count
  wire [FW-1:0] remain = feed - issued;
  wire more = counted ? (issued < feed) : 1'b1;
  wire last_one = counted && remain == 24'h000001;
  wire down_now = hi_start && (st == ST_DECEL || (counted && remain <= ramp_n));
  // acceleration starts once n-1 idling pulses are out
  wire accel_ok = idle_set < 3'h2 || issued >= FW'(idle_set - 3'h1);

  // period for the pulse about to fire
  wire [PW-1:0] per_dn = ramp_dn(cur_per, step_per, high_per);
  wire [PW-1:0] per_up = ramp_up(cur_per, step_per, start_per);
  wire [PW-1:0] per_now = !hi_start ? cur_per : down_now ? per_up : accel_ok ? per_dn : cur_per;

  // width: held constant at slow rates when control is on, half period otherwise
  wire slow = !wdis && 32'(per_now) > 32'(SLOW_PER_P);
  wire [PW-1:0] half = (per_now >> 1) == '0 ? 20'h00001 : per_now >> 1;
  wire [PW-1:0] wid_now = slow ? PW'(HOLD_CYC_P) : half;

  // decel stop ends once start speed is reached
  wire dec_done = st == ST_DECEL && cur_per >= start_per;
  wire fire = moving && pg.ready && more && !stop_imm && !dec_done;
  // completion point chosen by the timing select bit
  wire end_hit = metm ? pg.wid_end : pg.cyc_end;
  wire finish = (st == ST_TAIL && end_hit) || stop_imm;

  assign pg.fire = fire;
  assign pg.abort = stop_imm;
  assign pg.quiet = timer;
  assign pg.per = per_now;
  assign pg.wid = wid_now;

  // sequencer next state
  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: begin
        if (start_ok) next_st = ST_RUN;
      end
      ST_RUN: begin
        if (stop_imm) next_st = ST_IDLE;
        else if (fire && last_one) next_st = ST_TAIL;
        else if (stop_dec) next_st = hi_start ? ST_DECEL : ST_TAIL;
      end
      ST_DECEL: begin
        if (stop_imm) next_st = ST_IDLE;
        else if ((fire && last_one) || dec_done) next_st = ST_TAIL;
      end
      ST_TAIL: begin
        if (end_hit || !pg.ready) next_st = end_hit ? ST_IDLE : ST_TAIL;
        else next_st = ST_IDLE;
      end
    endcase
  end

  // state, stays idle after any stop until software starts again
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) st <= ST_IDLE;
    else st <= next_st;
  end

  // per-operation motion state
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir <= 1'b0;
      hi_start <= 1'b0;
      issued <= '0;
      ramp_n <= '0;
      cur_per <= SPER_RST;
      idle_ctr <= '0;
    end else if (start_ok) begin
      dir <= req_dir;
      hi_start <= reg_wdata_i[B_HI];
      issued <= '0;
      ramp_n <= '0;
      cur_per <= start_per;
      idle_ctr <= '0;
    end else if (fire) begin
      issued <= issued + 24'h000001;
      cur_per <= per_now;
      if (per_now < cur_per) ramp_n <= ramp_n + 24'h000001;
      else if (per_now > cur_per && ramp_n != '0) ramp_n <= ramp_n - 24'h000001;
      if (idle_ctr < idle_set) idle_ctr <= idle_ctr + 3'h1;
    end
  end

  // software settings
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_mode <= M_POS;
      metm <= 1'b0;
      stop_meth <= 1'b0;
      fdis <= 1'b0;
      wdis <= 1'b0;
      idle_set <= '0;
      feed <= FEED_RST;
      start_per <= SPER_RST;
      high_per <= HPER_RST;
      step_per <= STEP_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        A_MODE: begin
          op_mode <= reg_wdata_i[1:0];
          metm <= reg_wdata_i[B_METM];
        end
        A_ENV1: begin
          stop_meth <= reg_wdata_i[B_ELM];
          fdis <= reg_wdata_i[B_FDIS];
          wdis <= reg_wdata_i[B_WDIS];
        end
        A_ENV2: idle_set <= reg_wdata_i[B_IDL+:3];
        A_FEED: feed <= reg_wdata_i[FW-1:0];
        A_SPER: start_per <= reg_wdata_i[PW-1:0];
        A_HPER: high_per <= reg_wdata_i[PW-1:0];
        A_STEP: step_per <= reg_wdata_i[PW-1:0];
        default: ;
      endcase
    end
  end

  // error causes: hardware set beats a software clear in the same cycle
  wire set_p = (hit_err && !dir) || (refused && !req_dir);
  wire set_m = (hit_err && dir) || (refused && req_dir);
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err_p <= 1'b0;
      err_m <= 1'b0;
    end else begin
      err_p <= set_p || (err_p && !(wr_err && reg_wdata_i[0]));
      err_m <= set_m || (err_m && !(wr_err && reg_wdata_i[1]));
    end
  end

  // read mux; unmapped words read zero
  wire [31:0] spd_word = {5'h00, idle_ctr, 4'h0, cur_per};
  wire [31:0] sts_word = {29'h0, m_act, p_act, !is_idle};
  wire [31:0] mode_word = {23'h0, metm, 6'h00, op_mode};
  wire [31:0] rd_sel = reg_addr_i == A_SPD ? spd_word :
                       reg_addr_i == A_STS ? sts_word :
                       reg_addr_i == A_ERR ? {30'h0, err_m, err_p} :
                       reg_addr_i == A_MODE ? mode_word :
                       reg_addr_i == A_FEED ? {8'h00, feed} : 32'h00000000;

  // read data valid the cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) reg_rdata_o <= '0;
    else reg_rdata_o <= reg_rd_i ? rd_sel : 32'h00000000;
  end

  // completion pulse and direction pin
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      done_q <= !is_idle && finish;
      dir_o <= start_ok ? req_dir : dir_o;
    end
  end

  assign pulse_o = pg.pulse;
  assign done_o = done_q;
  assign busy_o = !is_idle;
endmodule // pielc_top

/* File: bench/pielc_chk.sv */
`timescale 1ns/10ps
// Purpose: port-level checks for the pulse, idling and end-limit axis block
// Assumes: mode, stop method and feed are shadowed from register writes
// Notes: limit age counters saturate at 31 cycles
module pielc_chk import pielc_pkg::*; #(
  parameter int HOLD_CYC_P = HOLD_CYC,
  parameter int SLOW_PER_P = SLOW_PER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic plus_end_limit_i,
  input wire logic minus_end_limit_i,
  input wire logic limit_polarity_pin_i,
  input wire logic pulse_o,
  input wire logic dir_o,
  input wire logic busy_o,
  input wire logic done_o
);
  logic [1:0] mode_q;
  logic elm_q;
  logic prev_p;
  logic [FW-1:0] feed_q;
  logic [FW-1:0] pcnt;
  logic [4:0] pon;
  logic [4:0] poff;
  logic [4:0] mon;
  // decoded strobes and active limit levels after polarity
  wire logic cmd_wr = reg_wr_i && reg_addr_i == A_CMD;
  wire logic start_wr = cmd_wr && reg_wdata_i[B_START];
  wire logic pa = plus_end_limit_i ^ limit_polarity_pin_i;
  wire logic ma = minus_end_limit_i ^ limit_polarity_pin_i;
  wire logic counted = mode_q == M_POS || mode_q == M_CONT;

  function automatic logic [4:0] age(input logic a, input logic [4:0] c);
    age = !a ? 5'h00 : (c == 5'h1F) ? c : c + 5'h01;
  endfunction

  // shadows; the age counters give the design room for sync and filter delay
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 2'h0;
      elm_q <= 1'b0;
      feed_q <= '0;
      pcnt <= '0;
      prev_p <= 1'b0;
      pon <= 5'h00;
      poff <= 5'h00;
      mon <= 5'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == A_MODE) mode_q <= reg_wdata_i[1:0];
      if (reg_wr_i && reg_addr_i == A_ENV1) elm_q <= reg_wdata_i[B_ELM];
      if (reg_wr_i && reg_addr_i == A_FEED) feed_q <= reg_wdata_i[FW-1:0];
      if (cmd_wr && !busy_o) pcnt <= '0;
      else if (pulse_o && !prev_p) pcnt <= pcnt + 1'b1;
      prev_p <= pulse_o;
      pon <= age(pa, pon);
      poff <= age(!pa, poff);
      mon <= age(ma, mon);
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_DONE_PULSE:
    assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  AST_ENV_WO:
    assert property (reg_rd_i && (reg_addr_i == A_ENV1 || reg_addr_i == A_ENV2) |=> reg_rdata_o == 32'h0)
      else $error("write-only word read back nonzero");
  AST_STS_PLUS_ON:
    assert property (reg_rd_i && reg_addr_i == A_STS && pon > 5'h13 |=> reg_rdata_o[1])
      else $error("plus limit status missing");
  AST_STS_PLUS_OFF:
    assert property (reg_rd_i && reg_addr_i == A_STS && poff > 5'h13 |=> !reg_rdata_o[1])
      else $error("plus limit status wrongly set");
  AST_STS_MINUS_ON:
    assert property (reg_rd_i && reg_addr_i == A_STS && mon > 5'h13 |=> reg_rdata_o[2])
      else $error("minus limit status missing");
  AST_NO_RESTART:
    assert property ($rose(busy_o) |-> $past(start_wr)) else $error("motion began without start");
  AST_START_REFUSE:
    assert property (start_wr && !reg_wdata_i[B_DIR] && pon > 5'h13 && !busy_o && counted |=> !busy_o)
      else $error("start toward active limit accepted");
  AST_TIMER_QUIET:
    assert property (mode_q == M_TIMER && busy_o |-> !pulse_o) else $error("pulse out in timer mode");
  AST_LIMIT_STOP:
    assert property (counted && !elm_q && !dir_o && pon > 5'h18 |-> !busy_o) else $error("no stop at limit");
  AST_FEED_BOUND:
    assert property (busy_o && mode_q == M_POS |-> pcnt <= feed_q) else $error("more pulses than feed");

  COV_START: cover property (start_wr);
  COV_DONE: cover property (done_o);
  COV_LIMIT_STOP: cover property ($fell(busy_o) && pon != 5'h00);
endmodule // pielc_chk

/* File: bench/pielc_motor_model.sv */
`timescale 1ns/10ps
// Purpose: stand-in for the motor driver and the two end-limit switches
// Assumes: the bench says which switch is pressed
// Notes: measures pulse count, last width and intervals in core cycles
module pielc_motor_model (
  input wire logic clk_i,
  input wire logic pol_i,
  input wire logic pulse_i,
  input wire logic clr_i,
  input wire logic plus_act_i,
  input wire logic minus_act_i,
  output logic plus_raw_o,
  output logic minus_raw_o
);
  int t = 0;
  int cnt = 0;
  int wid = 0;
  int last_rise = 0;
  int last_fall = 0;
  int iv [0:15];
  logic prev = 1'b0;
  // switches follow the polarity pin and hold exactly as long as pressed
  assign plus_raw_o = plus_act_i ^ pol_i;
  assign minus_raw_o = minus_act_i ^ pol_i;
  // the driver takes one step per rising edge; intervals kept for the first 16
  always @(posedge clk_i) begin
    t <= t + 1;
    prev <= pulse_i;
    if (clr_i) begin
      cnt <= 0;
    end else if (pulse_i && !prev) begin
      if (cnt > 0 && cnt < 17) iv[cnt-1] <= t - last_rise;
      cnt <= cnt + 1;
      last_rise <= t;
    end
    if (!pulse_i && prev) begin
      wid <= t - last_rise;
      last_fall <= t;
    end
  end
endmodule // pielc_motor_model

/* File: bench/tb_pulse_idle_end_limit_ctrl.sv */
`timescale 1ns/10ps
// Purpose: self-checking bench for the pulse, idling and end-limit axis block
// Assumes: hold width shortened to 40 and slow period to 80 cycles
// Notes: all register traffic passes through bus_wr and bus_rd
module tb_pulse_idle_end_limit_ctrl;
  import pielc_pkg::*;
  localparam int HP = 40;
  localparam int SP = 80;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pol = 1'b0;
  logic pa = 1'b0;
  logic ma = 1'b0;
  logic clr = 1'b0;
  logic [31:0] rdata;
  logic plus_raw, minus_raw, pulse, dir, busy, done;
  logic [31:0] v;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int done_t = 0;
  int d0 = 0;

  always #5 clk = ~clk;
  // cycle stamp kept in step with the model's own count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) done_t <= cyc;
  end

  pielc_top #(.HOLD_CYC_P(HP), .SLOW_PER_P(SP)) i_dut (
    .core_clk_i(clk), .rstn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .plus_end_limit_i(plus_raw), .minus_end_limit_i(minus_raw),
    .limit_polarity_pin_i(pol), .pulse_o(pulse), .dir_o(dir), .busy_o(busy), .done_o(done)
  );
  pielc_motor_model i_mot (
    .clk_i(clk), .pol_i(pol), .pulse_i(pulse), .clr_i(clr), .plus_act_i(pa), .minus_act_i(ma),
    .plus_raw_o(plus_raw), .minus_raw_o(minus_raw)
  );

  task automatic close_out;
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // bounded wait on busy; running out counts as a mismatch and ends the run
  task automatic wait_busy(input logic lvl, input int n, input string m);
    for (int i = 0; i < n && busy !== lvl; i++) @(posedge clk);
    num_checks++;
    if (busy !== lvl) begin
      err_total++;
      $display("[FAIL] %0t %s timed out", $time, m);
      close_out();
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands one cycle; read just after the edge, before it clears
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clear_model;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic run(input logic [31:0] cmd);
    bus_wr(A_CMD, cmd);
    wait_busy(1'b1, 5, "start");
    wait_busy(1'b0, 20000, "finish");
    hold(1); // stamps taken at the falling edge of busy settle first
  endtask

  initial begin
    hold(16);
    rst_n <= 1'b1;
    hold(3);
    bus_rd(4'hF, v);
    chk(v, 32'h0, "unmapped read");
    bus_wr(A_SPER, 32'h64);
    bus_wr(A_FEED, 32'h2);
    bus_wr(A_ENV1, 32'h0);
    // done moves by period minus width between the two timings
    for (int m = 0; m < 2; m++) begin
      bus_wr(A_MODE, m == 1 ? 32'h100 : 32'h0);
      run(32'h1);
      if (m == 0) d0 = done_t - i_mot.last_fall;
      else chk(d0 - (done_t - i_mot.last_fall), 32'h3C, "completion timing");
    end
    bus_wr(A_MODE, 32'h0);
    // held width at slow rate, half duty when disabled or fast
    for (int k = 0; k < 3; k++) begin
      bus_wr(A_SPER, k == 2 ? 32'h3C : 32'h64);
      bus_wr(A_ENV1, k == 1 ? 32'h0200_0000 : 32'h0);
      run(32'h1);
      chk(i_mot.wid, k == 0 ? HP : (k == 1 ? 32'h32 : 32'h1E), "pulse width");
    end
    bus_wr(A_SPER, 32'h64);
    bus_wr(A_HPER, 32'h14);
    bus_wr(A_STEP, 32'h28);
    bus_wr(A_FEED, 32'hC);
    // every idle setting, ramped start
    for (int n = 0; n < 8; n++) begin
      bus_wr(A_ENV2, 32'(n) << B_IDL);
      clear_model();
      run(32'h21);
      chk(i_mot.cnt, 32'hC, "feed total");
      for (int k = 0; k < n - 1; k++) chk(i_mot.iv[k], 32'h64, "idle period");
      chk({31'h0, i_mot.iv[n < 2 ? 0 : n - 1] < 100}, 32'h1, "accel start");
      bus_rd(A_SPD, v);
      chk({29'h0, v[26:24]}, 32'(n), "idle counter");
    end
    bus_rd(A_ENV2, v);
    chk(v, 32'h0, "write-only idle setting");
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      pa <= 1'b1;
      hold(30);
      bus_rd(A_STS, v);
      chk(v, 32'h2, "plus status");
      pa <= 1'b0;
      ma <= 1'b1;
      hold(30);
      bus_rd(A_STS, v);
      chk(v, 32'h4, "minus status");
      ma <= 1'b0;
    end
    pa <= 1'b1;
    hold(30);
    bus_wr(A_MODE, 32'h1);
    bus_wr(A_CMD, 32'h1);
    hold(4);
    chk({31'h0, busy}, 32'h0, "start refused");
    bus_rd(A_ERR, v);
    chk(v, 32'h1, "refusal error");
    bus_wr(A_ERR, 32'h1);
    bus_rd(A_ERR, v);
    chk(v, 32'h0, "error cleared");
    pa <= 1'b0;
    hold(30);
    // immediate stop, opposite limit ignored, no restart on release
    bus_wr(A_CMD, 32'h1);
    hold(200);
    ma <= 1'b1;
    hold(60);
    chk({31'h0, busy}, 32'h1, "opposite limit");
    ma <= 1'b0;
    pa <= 1'b1;
    wait_busy(1'b0, 50, "limit stop");
    pa <= 1'b0;
    clear_model();
    hold(300);
    chk(i_mot.cnt, 32'h0, "no restart");
    bus_rd(A_ERR, v);
    chk(v, 32'h1, "limit error");
    bus_wr(A_ERR, 32'h3);
    // software stop commands: decel from a flat start ends the pulse, immediate ends at once
    bus_wr(A_CMD, 32'h1);
    bus_wr(A_CMD, 32'h4);
    wait_busy(1'b0, 200, "decel command");
    bus_wr(A_CMD, 32'h1);
    bus_wr(A_CMD, 32'h2);
    wait_busy(1'b0, 3, "stop command");
    // deceleration stop from a ramped minus run
    bus_wr(A_ENV1, 32'h8);
    bus_wr(A_CMD, 32'h31);
    // past the six idling pulses, so the stop begins from full speed
    hold(900);
    chk({31'h0, dir}, 32'h1, "minus direction");
    clear_model();
    ma <= 1'b1;
    wait_busy(1'b0, 2000, "decel stop");
    bus_rd(A_SPD, v);
    chk({12'h0, v[19:0]}, 32'h64, "decel ramp");
    ma <= 1'b0;
    bus_wr(A_ERR, 32'h3);
    // short limit pulse: ignored filtered, acted on unfiltered
    bus_wr(A_ENV1, 32'h0);
    bus_wr(A_CMD, 32'h1);
    hold(100);
    pa <= 1'b1;
    hold(10);
    pa <= 1'b0;
    hold(60);
    chk({31'h0, busy}, 32'h1, "short pulse ignored");
    bus_wr(A_ENV1, 32'h0100_0000);
    pa <= 1'b1;
    hold(5);
    pa <= 1'b0;
    wait_busy(1'b0, 50, "unfiltered stop");
    bus_wr(A_ERR, 32'h3);
    bus_wr(A_MODE, 32'h2);
    bus_wr(A_FEED, 32'h3);
    pa <= 1'b1;
    hold(30);
    clear_model();
    run(32'h1);
    chk(i_mot.cnt, 32'h0, "timer silent");
    bus_rd(A_STS, v);
    chk(v, 32'h2, "timer status");
    bus_rd(A_ERR, v);
    chk(v, 32'h0, "timer error");
    pa <= 1'b0;
    hold(30);
    bus_wr(A_MODE, 32'h3);
    bus_wr(A_CMD, 32'h1);
    hold(100);
    pa <= 1'b1;
    wait_busy(1'b0, 50, "origin stop");
    bus_rd(A_ERR, v);
    chk(v, 32'h0, "origin error");
    close_out();
  end
endmodule // tb_pulse_idle_end_limit_ctrl

bind pielc_top pielc_chk #(.HOLD_CYC_P(HOLD_CYC_P), .SLOW_PER_P(SLOW_PER_P)) i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .plus_end_limit_i(plus_end_limit_i),
  .minus_end_limit_i(minus_end_limit_i), .limit_polarity_pin_i(limit_polarity_pin_i), .pulse_o(pulse_o),
  .dir_o(dir_o), .busy_o(busy_o), .done_o(done_o)
);
